// ### include/vector_select_pkg.sv
// Constants, field layouts and carrier types for the interrupt vector selector.
package vector_select_pkg;

	// Table geometry.
	localparam int NUM_TRAPS = 8;
	localparam int NUM_IRQS = 118;
	localparam int NUM_VECTORS = 126;
	localparam int VEC_ADDR_W = 24;
	localparam int VEC_NUM_W = 7;
	localparam int TRAP_NUM_W = 3;
	localparam int LEVEL_W = 4;
	localparam int PRIO_W = 3;
	localparam int NUM_LEVELS = 8;

	// Program memory word addresses.
	localparam logic [23:0] RESET_ADDR = 24'h000000;
	localparam logic [23:0] RESET_JUMP_TARGET = 24'h000002;
	localparam logic [23:0] PRIMARY_BASE = 24'h000004;
	localparam logic [23:0] ALT_OFFSET = 24'h000100;
	localparam logic [23:0] ALT_BASE = 24'h000104;
	localparam logic [23:0] PRIMARY_IRQ_BASE = 24'h000014;
	localparam logic [23:0] ALT_IRQ_BASE = 24'h000114;
	localparam logic [23:0] PRIMARY_LAST = 24'h0000fe;
	localparam logic [23:0] ALT_LAST = 24'h0001fe;
	localparam logic [6:0] IRQ_INDEX_OFFSET = 7'h08;

	// Trap vector numbers; 0, 5, 6 and 7 are reserved.
	localparam logic [2:0] TRAP_OSC_FAIL = 3'h1;
	localparam logic [2:0] TRAP_ADDR_ERR = 3'h2;
	localparam logic [2:0] TRAP_STACK_ERR = 3'h3;
	localparam logic [2:0] TRAP_MATH_ERR = 3'h4;
	localparam logic [3:0] TRAP_LEVEL = 4'hf;

	// Interrupt vector numbers of the named peripheral sources.
	localparam logic [4:0][6:0] EXT_VEC = {7'h36, 7'h35, 7'h1d, 7'h14, 7'h00};
	localparam logic [1:0][6:0] CAPTURE_VEC = {7'h05, 7'h01};
	localparam logic [1:0][6:0] COMPARE_VEC = {7'h06, 7'h02};
	localparam logic [4:0][6:0] TIMER_VEC = {7'h1c, 7'h1b, 7'h08, 7'h07, 7'h03};
	localparam logic [6:0] ADC_DONE_VEC = 7'h0d;
	localparam logic [6:0] SERIAL_RX_VEC = 7'h0b;
	localparam logic [6:0] SERIAL_TX_VEC = 7'h0c;
	localparam logic [6:0] SERIAL_ERR_VEC = 7'h41;

	// Register map on the plain register port.
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 16;
	localparam logic [3:0] REG_CONTROL_TWO = 4'h0;
	localparam logic [3:0] REG_LATCHED = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam int ALT_SELECT_BIT = 15;
	localparam int LATCHED_NUM_LSB = 0;
	localparam int LATCHED_LVL_LSB = 8;
	localparam int STATUS_PEND_BIT = 15;
	localparam int STATUS_TRAP_BIT = 14;
	localparam int STATUS_STATE_LSB = 8;
	localparam int STATUS_NUM_LSB = 0;
	localparam logic [15:0] RESET_DATA = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQUEST = 2'b01,
		ST_TAKEN = 2'b11
	} fsm_type;

	typedef struct packed {
		logic [REG_ADDR_W-1:0] addr;
		logic [REG_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;

	typedef struct packed {
		logic [4:0] ext_int;
		logic [1:0] capture;
		logic [1:0] compare;
		logic adc_done;
		logic [4:0] timer;
		logic serial_rx;
		logic serial_tx;
		logic serial_err;
	} periph_irq_type;

	typedef logic [NUM_IRQS-1:0][PRIO_W-1:0] prio_array_type;

endpackage

// ### rtl/lowest_index_picker.sv
// Fixed-order picker that returns the lowest set bit of a request vector.
`timescale 1ns/1ps
module lowest_index_picker
	import vector_select_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int IDX_W = 3
) (
	// Requests.
	input wire logic [WIDTH-1:0] req_i,
	// Result.
	output logic valid_o,
	output logic [IDX_W-1:0] index_o
);

	// Scanning downward lets the lowest index overwrite every higher one.
	always_comb begin
		valid_o = 1'b0;
		index_o = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				valid_o = 1'b1;
				index_o = IDX_W'(i);
			end
		end
	end

endmodule // lowest_index_picker

// ### rtl/interrupt_vector_selector.sv
// Interrupt vector selector: resolves traps and interrupts into one vector fetch.
//
// Notes on behaviour
// R1: Primary table starts at word address 000004h, after the reset entry.
// R2: Table holds 126 entries: 8 traps then up to 118 interrupts.
// R3: Each entry is a 24-bit program address where the handler starts.
// R4: Among equal requests the lower table address wins; vector 0 wins all.
// R5: Every implemented source has its own vector, none shared.
// R6: Traps are non-maskable, vectors 0 to 7 at 000004h to 000012h.
// R7: Interrupt vector n sits at 000014h plus 2n, last at 0000FEh.
// R8: Alternate table lies 100h higher, traps from 000104h, interrupts to 0001FEh.
// R9: With the alternate select bit set every vector comes from the alternate table.
// R10: Alternate table keeps the primary ordering and numbering.
// R11: Reset bypasses the controller and sends fetching to address 000000h.
// R12: Software puts a jump at 000000h with its target at 000002h.
// R13: Software fills unused entries with a handler that resets the device.
// R14: Software copies the primary table into an unused alternate table.
// R15: External, capture, compare and conversion-done sources map to fixed vectors.
// R16: Timers and first serial port events map to fixed vectors.
// R17: All requests reduce to one request line to the core.
// R18: Within one priority level arbitration follows natural vector order.
// R19: Taken vector number and new level are latched into a readable register.
// R20: Fetch address is table base plus twice the index; interrupts add eight.
`timescale 1ns/1ps
module interrupt_vector_selector
	import vector_select_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port.
	input wire bus_req_type bus_i,
	output logic [REG_DATA_W-1:0] rd_data_o,
	// Trap and interrupt requests.
	input wire logic [NUM_TRAPS-1:0] trap_i,
	input wire periph_irq_type periph_i,
	input wire logic [NUM_IRQS-1:0] other_irq_i,
	input wire prio_array_type prio_i,
	// Core side.
	input wire logic [LEVEL_W-1:0] cpu_level_i,
	input wire logic core_ack_i,
	output logic irq_o,
	output logic [VEC_ADDR_W-1:0] vector_addr_o,
	output logic [VEC_NUM_W-1:0] vector_num_o,
	output logic vector_is_trap_o,
	output logic [LEVEL_W-1:0] new_level_o,
	output logic vector_taken_o
);

	typedef struct packed {
		fsm_type fsm;
		logic irq;
		logic [VEC_ADDR_W-1:0] vec_addr;
		logic [VEC_NUM_W-1:0] vec_num;
		logic is_trap;
		logic [LEVEL_W-1:0] level;
		logic taken;
		logic alt_table_select;
		logic [VEC_NUM_W-1:0] latched_vector_number;
		logic [LEVEL_W-1:0] latched_priority_level;
		logic [REG_DATA_W-1:0] rd_data;
	} state_type;

	localparam state_type STATE_RESET = '{
		fsm: ST_IDLE,
		irq: 1'b0,
		vec_addr: RESET_ADDR,
		vec_num: '0,
		is_trap: 1'b0,
		level: '0,
		taken: 1'b0,
		alt_table_select: 1'b0,
		latched_vector_number: '0,
		latched_priority_level: '0,
		rd_data: RESET_DATA
	};

	state_type state;
	state_type next_state;

	logic [NUM_IRQS-1:0] irq_req;
	logic [NUM_LEVELS-1:0][NUM_IRQS-1:0] lvl_req;
	logic [PRIO_W-1:0] best_level;
	logic [NUM_IRQS-1:0] best_row;
	logic irq_valid;
	logic [VEC_NUM_W-1:0] irq_index;
	logic trap_valid;
	logic [TRAP_NUM_W-1:0] trap_index;
	logic sel_valid;
	logic sel_is_trap;
	logic [VEC_NUM_W-1:0] sel_num;
	logic [VEC_NUM_W-1:0] sel_table_index;
	logic [LEVEL_W-1:0] sel_level;
	logic [VEC_ADDR_W-1:0] sel_base;
	logic [VEC_ADDR_W-1:0] sel_addr;

	// Named peripheral sources are folded onto their fixed vector slots, so
	// each slot has exactly one owner beyond the generic request lines.
	always_comb begin
		irq_req = other_irq_i; // R5
		for (int e = 0; e < 5; e++) begin
			irq_req[EXT_VEC[e]] = irq_req[EXT_VEC[e]] | periph_i.ext_int[e]; // R15
			irq_req[TIMER_VEC[e]] = irq_req[TIMER_VEC[e]] | periph_i.timer[e]; // R16
		end
		for (int c = 0; c < 2; c++) begin
			irq_req[CAPTURE_VEC[c]] = irq_req[CAPTURE_VEC[c]] | periph_i.capture[c]; // R15
			irq_req[COMPARE_VEC[c]] = irq_req[COMPARE_VEC[c]] | periph_i.compare[c]; // R15
		end
		irq_req[ADC_DONE_VEC] = irq_req[ADC_DONE_VEC] | periph_i.adc_done; // R15
		irq_req[SERIAL_RX_VEC] = irq_req[SERIAL_RX_VEC] | periph_i.serial_rx; // R16
		irq_req[SERIAL_TX_VEC] = irq_req[SERIAL_TX_VEC] | periph_i.serial_tx; // R16
		irq_req[SERIAL_ERR_VEC] = irq_req[SERIAL_ERR_VEC] | periph_i.serial_err; // R16
	end

	// Sort every request into its priority row. Level zero never fires, and a
	// request must outrank the level the core is currently running at.
	for (genvar i = 0; i < NUM_IRQS; i++) begin : g_level_rows
		logic eligible;
		assign eligible = irq_req[i] && ({1'b0, prio_i[i]} > cpu_level_i);
		for (genvar l = 0; l < NUM_LEVELS; l++) begin : g_level
			if (l == 0) begin : g_off
				assign lvl_req[l][i] = 1'b0;
			end else begin : g_on
				assign lvl_req[l][i] = eligible && (prio_i[i] == PRIO_W'(l)); // R18
			end
		end
	end

	// The highest populated level is chosen first; the picker then resolves
	// ties inside that level by natural order.
	always_comb begin
		best_level = '0;
		for (int l = 1; l < NUM_LEVELS; l++) begin
			if (|lvl_req[l]) begin
				best_level = PRIO_W'(l);
			end
		end
		best_row = lvl_req[best_level];
	end

	lowest_index_picker #(
		.WIDTH(NUM_IRQS), // R2
		.IDX_W(VEC_NUM_W)
	) u_irq_picker (
		.req_i(best_row),
		.valid_o(irq_valid),
		.index_o(irq_index)
	); // R18

	lowest_index_picker #(
		.WIDTH(NUM_TRAPS), // R2
		.IDX_W(TRAP_NUM_W)
	) u_trap_picker (
		.req_i(trap_i),
		.valid_o(trap_valid),
		.index_o(trap_index)
	); // R4

	// Traps sit below every interrupt in the table, so natural order alone
	// lets any trap outrank any interrupt; no level gate applies to them.
	always_comb begin
		sel_valid = trap_valid | irq_valid; // R17
		sel_is_trap = trap_valid; // R6
		if (trap_valid) begin
			sel_num = {4'h0, trap_index};
			sel_table_index = {4'h0, trap_index}; // R20
			sel_level = TRAP_LEVEL;
		end else begin
			sel_num = irq_index;
			sel_table_index = irq_index + IRQ_INDEX_OFFSET; // R20
			sel_level = {1'b0, best_level};
		end
	end

	// Both tables share one layout, so only the base differs between them.
	always_comb begin
		if (state.alt_table_select) begin
			sel_base = ALT_BASE; // R9 R8 R10
		end else begin
			sel_base = PRIMARY_BASE; // R1
		end
		sel_addr = sel_base + {16'h0000, sel_table_index, 1'b0}; // R20 R7 R3
	end

	always_comb begin
		next_state = state;
		next_state.taken = 1'b0;
		next_state.rd_data = RESET_DATA;

		if (bus_i.wr) begin
			unique case (bus_i.addr)
				REG_CONTROL_TWO: begin
					next_state.alt_table_select = bus_i.wdata[ALT_SELECT_BIT]; // R9
				end
				default: begin
				end
			endcase
		end

		if (bus_i.rd) begin
			unique case (bus_i.addr)
				REG_CONTROL_TWO: begin
					next_state.rd_data[ALT_SELECT_BIT] = state.alt_table_select;
				end
				REG_LATCHED: begin
					next_state.rd_data[LATCHED_NUM_LSB +: VEC_NUM_W] =
						state.latched_vector_number; // R19
					next_state.rd_data[LATCHED_LVL_LSB +: LEVEL_W] =
						state.latched_priority_level; // R19
				end
				REG_STATUS: begin
					next_state.rd_data[STATUS_PEND_BIT] = state.irq;
					next_state.rd_data[STATUS_TRAP_BIT] = state.is_trap;
					next_state.rd_data[STATUS_STATE_LSB +: 2] = state.fsm;
					next_state.rd_data[STATUS_NUM_LSB +: VEC_NUM_W] = state.vec_num;
				end
				default: begin
				end
			endcase
		end

		unique case (state.fsm)
			ST_IDLE: begin
				if (sel_valid) begin
					next_state.fsm = ST_REQUEST;
					next_state.irq = 1'b1; // R17
					next_state.vec_addr = sel_addr;
					next_state.vec_num = sel_num;
					next_state.is_trap = sel_is_trap;
					next_state.level = sel_level;
				end
			end
			ST_REQUEST: begin
				if (core_ack_i) begin
					// The core takes what it saw at this edge, not a newer winner.
					next_state.fsm = ST_TAKEN;
					next_state.irq = 1'b0;
					next_state.taken = 1'b1;
					next_state.latched_vector_number = state.vec_num; // R19
					next_state.latched_priority_level = state.level; // R19
				end else if (sel_valid) begin
					// A better request arriving before the acknowledge replaces
					// the one on offer; one arriving in the acknowledge cycle is not fetched.
					next_state.vec_addr = sel_addr; // R4
					next_state.vec_num = sel_num;
					next_state.is_trap = sel_is_trap;
					next_state.level = sel_level;
				end else begin
					next_state.fsm = ST_IDLE;
					next_state.irq = 1'b0;
				end
			end
			ST_TAKEN: begin
				// One idle cycle lets the core raise its level before the next
				// arbitration, otherwise the same flag would be offered again.
				next_state.fsm = ST_IDLE;
			end
		endcase
	end

	// Reset never passes through arbitration; it parks the vector address at
	// the reset entry so fetching restarts from address zero.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state <= STATE_RESET; // R11
		end else begin
			state <= next_state;
		end
	end

	assign irq_o = state.irq;
	assign vector_addr_o = state.vec_addr;
	assign vector_num_o = state.vec_num;
	assign vector_is_trap_o = state.is_trap;
	assign new_level_o = state.level;
	assign vector_taken_o = state.taken;
	assign rd_data_o = state.rd_data;

endmodule // interrupt_vector_selector

// ### dv/vector_selector_sva.sv
// Assertions for the interrupt vector selector ports.
`timescale 1ns/1ps
module vector_selector_sva
	import vector_select_pkg::*;
(
	// Inputs of the design.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire bus_req_type bus_i,
	input wire logic [7:0] trap_i,
	input wire logic [3:0] cpu_level_i,
	input wire logic core_ack_i,
	// Outputs of the design.
	input wire logic [15:0] rd_data_o,
	input wire logic irq_o,
	input wire logic [23:0] vector_addr_o,
	input wire logic [6:0] vector_num_o,
	input wire logic vector_is_trap_o,
	input wire logic [3:0] new_level_o,
	input wire logic vector_taken_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic alt;
	// Table select mirrored from bus writes, so no internal probe is needed.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			alt <= 1'b0;
		end else if (bus_i.wr && bus_i.addr == 4'h0) begin
			alt <= bus_i.wdata[15];
		end
	end
	property p_addr;
		irq_o && $stable(alt) |-> vector_addr_o == (alt ? 24'h000104 : 24'h000004)
			+ {16'h0, vector_num_o + (vector_is_trap_o ? 7'h00 : 7'h08), 1'b0};
	endproperty
	a_addr: assert property (p_addr) else $error("fetch address wrong");
	property p_trap_lvl;
		irq_o && vector_is_trap_o |-> new_level_o == 4'hf && vector_num_o < 7'h08;
	endproperty
	a_trap_lvl: assert property (p_trap_lvl) else $error("trap level wrong");
	property p_trap_first;
		irq_o |-> vector_is_trap_o == ($past(trap_i) != 8'h00);
	endproperty
	a_trap_first: assert property (p_trap_first) else $error("trap not first");
	property p_trap_low;
		irq_o && vector_is_trap_o |-> (($past(trap_i) >> vector_num_o[2:0]) & 8'h01) == 8'h01
			&& ($past(trap_i) & ((8'h01 << vector_num_o[2:0]) - 8'h01)) == 8'h00;
	endproperty
	a_trap_low: assert property (p_trap_low) else $error("trap order wrong");
	property p_int_lvl;
		irq_o && !vector_is_trap_o |-> new_level_o > $past(cpu_level_i) && vector_num_o < 7'h76;
	endproperty
	a_int_lvl: assert property (p_int_lvl) else $error("interrupt level wrong");
	property p_take;
		irq_o && core_ack_i |=> vector_taken_o && !irq_o;
	endproperty
	a_take: assert property (p_take) else $error("ack not taken");
	property p_pulse;
		vector_taken_o |=> !vector_taken_o && !irq_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("taken pulse too long");
	property p_rd_idle;
		!$past(bus_i.rd) |-> rd_data_o == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	c_trap: cover property (irq_o && core_ack_i && vector_is_trap_o);
	c_alt: cover property (alt && irq_o && core_ack_i);
	c_int: cover property (irq_o && core_ack_i && !vector_is_trap_o);
endmodule // vector_selector_sva

bind interrupt_vector_selector vector_selector_sva u_sva (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .bus_i(bus_i), .trap_i(trap_i), .cpu_level_i(cpu_level_i),
	.core_ack_i(core_ack_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
	.vector_addr_o(vector_addr_o), .vector_num_o(vector_num_o),
	.vector_is_trap_o(vector_is_trap_o), .new_level_o(new_level_o),
	.vector_taken_o(vector_taken_o));

// ### dv/core_model.sv
// Processor core stand-in that acknowledges the request line after a set wait.
`timescale 1ns/1ps
module core_model (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Request side.
	input wire logic irq_i,
	input wire logic [3:0] wait_i,
	input wire logic [23:0] vec_addr_i,
	output logic ack_o,
	// Handler address the core jumps to after a fetch.
	output logic [23:0] handler_o
);
	// Program words are the software's choice; these values are arbitrary.
	localparam logic [23:0] JUMP_WORD = 24'h0a5a5a;
	localparam logic [23:0] START_ADDR = 24'h000200;
	localparam logic [23:0] DEFAULT_HANDLER = 24'h000300;
	localparam logic [23:0] HANDLER_BASE = 24'h000800;
	logic [3:0] cnt;
	logic [23:0] pmem [0:255];
	// Word index is the fetch address over two; reserved traps get the default handler.
	initial begin
		for (int e = 0; e < 256; e++) begin
			pmem[e] = DEFAULT_HANDLER;
		end
		pmem[0] = JUMP_WORD;
		pmem[1] = START_ADDR;
		for (int e = 1; e < 5; e++) begin
			pmem[e + 2] = HANDLER_BASE + {13'h0, e[6:0], 4'h0};
		end
		for (int e = 8; e < 126; e++) begin
			pmem[e + 2] = HANDLER_BASE + {13'h0, e[6:0], 4'h0};
		end
		for (int e = 0; e < 126; e++) begin
			pmem[e + 130] = pmem[e + 2];
		end
	end
	// After reset the core follows the jump at the reset word to its target.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			handler_o <= pmem[1];
		end else if (ack_o && irq_i) begin
			handler_o <= pmem[vec_addr_i[8:1]];
		end
	end
	// The ack is one cycle long and is only raised while the request still stands.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || ack_o || !irq_i) begin
			ack_o <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt == wait_i) begin
			ack_o <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // core_model

// ### dv/interrupt_vector_selector_tb.sv
// Self-checking bench for the interrupt vector selector.
`timescale 1ns/1ps
module interrupt_vector_selector_tb;
	import vector_select_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	bus_req_type bus_i = '0;
	logic [7:0] trap_i = '0;
	periph_irq_type periph_i = '0;
	logic [117:0] other_irq_i = '0;
	prio_array_type prio_i = '0;
	logic [3:0] cpu_level_i = '0;
	logic [3:0] wait_c = '0;
	logic ack, irq_o, trap_o, taken_o, alt = 1'b0, rd_pend = 1'b0;
	logic [15:0] rd_data_o;
	logic [23:0] addr_o;
	logic [6:0] num_o, n;
	logic [3:0] lvl_o;
	logic [2:0] p;
	logic [15:0] lf = 16'h0056;
	logic [35:0] vq[$];
	logic [15:0] rq[$];
	logic [23:0] hq[$];
	logic [23:0] hnd;
	int err_total = 0, n_compared = 0, cyc = 0;
	// Vector of each named source, indexed by bit of the packed source struct.
	int map[18] = '{65, 12, 11, 3, 7, 8, 27, 28, 13, 2, 6, 1, 5, 0, 20, 29, 53, 54};
	always #20 ref_clk_i = ~ref_clk_i;
	interrupt_vector_selector dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
		.rd_data_o(rd_data_o), .trap_i(trap_i), .periph_i(periph_i), .other_irq_i(other_irq_i),
		.prio_i(prio_i), .cpu_level_i(cpu_level_i), .core_ack_i(ack), .irq_o(irq_o),
		.vector_addr_o(addr_o), .vector_num_o(num_o), .vector_is_trap_o(trap_o),
		.new_level_o(lvl_o), .vector_taken_o(taken_o));
	core_model u_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .irq_i(irq_o),
		.wait_i(wait_c), .vec_addr_i(addr_o), .ack_o(ack), .handler_o(hnd));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic fail(input string m);
		err_total++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic cmp_vec(input logic [35:0] e, input logic [35:0] g);
		n_compared++;
		if (g !== e) fail($sformatf("vector %h expected %h", g, e));
	endtask
	task automatic cmp_rd(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) fail($sformatf("read %h expected %h", g, e));
	endtask
	task automatic cmp_hnd(input logic [23:0] e, input logic [23:0] g);
		n_compared++;
		if (g !== e) fail($sformatf("handler %h expected %h", g, e));
	endtask
	task automatic report_and_stop();
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rq.push_back(e);
		bus_i <= '{a, 16'h0, 1'b0, 1'b1};
		@(posedge ref_clk_i);
	endtask
	// Requests stay up until the vector is taken, then all are withdrawn together.
	task automatic shot(input logic [6:0] v, input logic t, input logic [3:0] l);
		logic [23:0] a;
		logic [6:0] e;
		int w;
		e = v + (t ? 7'h00 : 7'h08);
		a = (alt ? 24'h000104 : 24'h000004) + {16'h0, e, 1'b0};
		vq.push_back({a, v, t, l});
		hq.push_back((t && (v == 7'h00 || v > 7'h04)) ? 24'h000300
			: 24'h000800 + {13'h0, e, 4'h0});
		wait_c <= lf[3:0];
		for (w = 0; w < 60 && taken_o !== 1'b1; w++) @(posedge ref_clk_i);
		if (taken_o !== 1'b1) fail("no vector taken");
		trap_i <= '0;
		periph_i <= '0;
		other_irq_i <= '0;
		cpu_level_i <= '0;
		@(posedge ref_clk_i);
		rd(4'h1, {4'h0, l, 1'b0, v});
		bus_i <= '0;
		@(posedge ref_clk_i);
		lf = lfsr(lf);
	endtask
	task automatic pair(input logic [6:0] a, b, input logic [2:0] pa, pb,
		input logic [3:0] c, input logic [6:0] v, input logic [3:0] l);
		other_irq_i <= (118'h1 << a) | (118'h1 << b);
		prio_i[a] <= pa;
		prio_i[b] <= pb;
		cpu_level_i <= c;
		shot(v, 1'b0, l);
	endtask
	always @(posedge ref_clk_i) begin
		if (irq_o === 1'b1 && ack === 1'b1) begin
			cmp_vec(vq.pop_front(), {addr_o, num_o, trap_o, lvl_o});
		end
		if (taken_o === 1'b1) cmp_hnd(hq.pop_front(), hnd);
		if (rd_pend) cmp_rd(rq.pop_front(), rd_data_o);
		rd_pend <= bus_i.rd === 1'b1;
		cyc++;
		if (cyc > 30000) begin
			fail("timeout");
			report_and_stop();
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		rd(4'h0, 16'h0000);
		for (int s = 0; s < 2; s++) begin
			alt = s[0];
			wr(4'h0, {s[0], 15'h0});
			rd(4'h0, {s[0], 15'h0});
			bus_i <= '0;
			for (int t = 0; t < 8; t++) begin
				trap_i <= 8'h01 << t;
				shot(t[6:0], 1'b1, 4'hf);
			end
			for (int b = 0; b < 18; b++) begin
				periph_i <= periph_irq_type'(18'h1 << b);
				prio_i[map[b]] <= 3'h1;
				shot(map[b][6:0], 1'b0, 4'h1);
			end
		end
		for (int k = 0; k < 24; k++) begin
			n = (lf[6:0] >= 7'h76) ? lf[6:0] - 7'h76 : lf[6:0];
			p = lf[10:8] | 3'h1;
			other_irq_i <= 118'h1 << n;
			prio_i[n] <= p;
			cpu_level_i <= {1'b0, p} - 4'h1;
			shot(n, 1'b0, {1'b0, p});
		end
		trap_i <= 8'h14;
		other_irq_i <= 118'h1;
		prio_i[0] <= 3'h7;
		shot(7'h02, 1'b1, 4'hf);
		pair(7'h05, 7'h09, 3'h3, 3'h3, 4'h0, 7'h05, 4'h3);
		pair(7'h05, 7'h09, 3'h3, 3'h6, 4'h0, 7'h09, 4'h6);
		pair(7'h05, 7'h09, 3'h4, 3'h5, 4'h4, 7'h09, 4'h5);
		wr(4'h7, 16'hffff);
		rd(4'h5, 16'h0000);
		rd(4'h0, {alt, 15'h0});
		bus_i <= '0;
		wait_c <= 4'hf;
		trap_i <= 8'h02;
		@(posedge ref_clk_i);
		rd(4'h2, 16'hc101);
		bus_i <= '0;
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		trap_i <= '0;
		repeat (2) @(posedge ref_clk_i);
		cmp_vec(36'h0, {addr_o, num_o, trap_o, lvl_o});
		cmp_hnd(24'h000200, hnd);
		rst_n_i <= 1'b1;
		alt = 1'b0;
		@(posedge ref_clk_i);
		rd(4'h0, 16'h0000);
		bus_i <= '0;
		repeat (4) @(posedge ref_clk_i);
		report_and_stop();
	end
endmodule // interrupt_vector_selector_tb
